// ==== gpp_defs.svh ====
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// Number of general pins in the port.
`define GPP_PIN_CNT 6

// Register bus widths.
`define GPP_ADDR_W 8
`define GPP_DATA_W 8

// Register offsets on the plain register port.
`define GPP_OFS_DIR 8'h00
`define GPP_OFS_SET 8'h01
`define GPP_OFS_CLR 8'h02
`define GPP_OFS_STS 8'h03

// Field position of the per-pin bits inside each register.
`define GPP_PIN_MSB 5
`define GPP_PIN_LSB 0

// Reset values: every pin starts as input with a low output latch.
`define GPP_DIR_RST 6'h00
`define GPP_LAT_RST 6'h00
`define GPP_DATA_RST 8'h00
`define GPP_RSV_RD 2'h0

`endif

// ==== gpp_ext_pins.sv ====
`timescale 1ns/1ps

module gpp_ext_pins (
  // Pad side of the port.
  input  gpp_pkg::gpp_pins_t pin_out,
  input  gpp_pkg::gpp_pins_t pin_oe_n,
  // Level the outside circuit puts on pins that the port releases.
  input  gpp_pkg::gpp_pins_t ext_level,
  output gpp_pkg::gpp_pins_t pin_wire
);
  import gpp_pkg::*;
  assign pin_wire = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : gpp_ext_pins

// ==== gpp_general_pin_port.sv ====
`timescale 1ns/1ps
`include "gpp_defs.svh"

module gpp_general_pin_port (
  // Clock and reset.
  input  logic              ref_clk,
  input  logic              reset_n,
  // Register port.
  input  gpp_pkg::gpp_addr_t reg_addr,
  input  gpp_pkg::gpp_data_t reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output gpp_pkg::gpp_data_t reg_rdata,
  // Serial-port roles from the pin-function selection.
  input  gpp_pkg::gpp_pins_t role_claim,
  input  gpp_pkg::gpp_pins_t role_is_out,
  input  gpp_pkg::gpp_pins_t role_level,
  // General pins, split into input, output and active-low enable.
  input  gpp_pkg::gpp_pins_t general_pin_x_in,
  output gpp_pkg::gpp_pins_t general_pin_x_out,
  output gpp_pkg::gpp_pins_t general_pin_x_oe_n,
  // Synchronised pin levels for the serial roles.
  output gpp_pkg::gpp_pins_t pin_level
);

  import gpp_pkg::*;

  gpp_state_t st_ff;
  gpp_state_t nxt_st;

  logic wr_dir;
  logic wr_set;
  logic wr_clr;
  logic rd_dir;
  logic rd_set;
  logic rd_clr;
  logic rd_sts;

  // Address decode for the four registers.
  always_comb begin
    wr_dir = 1'b0;
    wr_set = 1'b0;
    wr_clr = 1'b0;
    rd_dir = 1'b0;
    rd_set = 1'b0;
    rd_clr = 1'b0;
    rd_sts = 1'b0;
    if (reg_addr == `GPP_OFS_DIR) begin
      wr_dir = reg_wr;
      rd_dir = reg_rd;
    end else if (reg_addr == `GPP_OFS_SET) begin
      wr_set = reg_wr;
      rd_set = reg_rd;
    end else if (reg_addr == `GPP_OFS_CLR) begin
      wr_clr = reg_wr;
      rd_clr = reg_rd;
    end else if (reg_addr == `GPP_OFS_STS) begin
      rd_sts = reg_rd;
    end
  end

  always_comb begin
    nxt_st = st_ff;

    // Only the second stage is read by other logic, since the first may be metastable.
    // two-stage sampling
    nxt_st.sync_a = general_pin_x_in;
    nxt_st.sync_b = st_ff.sync_a;

    // Bits 7 and 6 of every write are dropped, so the reserved bits always read as zero.
    // direction store
    if (wr_dir) begin
      nxt_st.dir = reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB];
    end

    if (wr_set) begin
      nxt_st.lat = st_ff.lat | reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB];
    end

    if (wr_clr) begin
      nxt_st.lat = st_ff.lat & ~reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB];
    end

    // The latch is kept apart from the pin, so writes to an input pin are not lost.
    // role overrides direction
    for (int i = 0; i < `GPP_PIN_CNT; i++) begin
      if (role_claim[i]) begin
        nxt_st.drv_out[i]  = role_level[i];
        nxt_st.drv_oe_n[i] = ~role_is_out[i];
      end else begin
        nxt_st.drv_out[i]  = nxt_st.lat[i];
        nxt_st.drv_oe_n[i] = ~nxt_st.dir[i];
      end
    end

    // Read data stands for exactly one cycle after the strobe.
    nxt_st.rdata = `GPP_DATA_RST;
    if (rd_dir) begin
      nxt_st.rdata = {`GPP_RSV_RD, st_ff.dir};
    end else if (rd_set || rd_clr) begin
      nxt_st.rdata = {`GPP_RSV_RD, st_ff.lat};
    end else if (rd_sts) begin
      nxt_st.rdata = {`GPP_RSV_RD, st_ff.sync_b};
    end
  end

  // Reset loads constants only, so every pin comes up as an undriven input.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff.dir      <= `GPP_DIR_RST;
      st_ff.lat      <= `GPP_LAT_RST;
      st_ff.sync_a   <= '0;
      st_ff.sync_b   <= '0;
      st_ff.drv_out  <= `GPP_LAT_RST;
      st_ff.drv_oe_n <= ~`GPP_DIR_RST;
      st_ff.rdata    <= `GPP_DATA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata          = st_ff.rdata;
  assign general_pin_x_out  = st_ff.drv_out;
  assign general_pin_x_oe_n = st_ff.drv_oe_n;
  assign pin_level          = st_ff.sync_b;

  // Checks on the port behaviour.
  // They are off while reset is low and resume at the first edge after release.
  default clocking chk_clk @(posedge ref_clk);
  endclocking

  default disable iff (!reset_n);

  chk_dir_store: assert property (
    (reg_wr && reg_addr == `GPP_OFS_DIR)
    |=> (st_ff.dir == $past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB]))
  ) else $error("direction register did not take the written value");

  chk_dir_enable: assert property (
    (reg_wr && reg_addr == `GPP_OFS_DIR && role_claim == '0)
    |=> (general_pin_x_oe_n == ~$past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB]))
  ) else $error("pin enables do not follow the written direction");

  chk_dir_readback: assert property (
    (reg_rd && reg_addr == `GPP_OFS_DIR)
    |=> (reg_rdata == {`GPP_RSV_RD, $past(st_ff.dir)})
  ) else $error("direction readback wrong or reserved bits not zero");

  chk_role_owns: assert property (
    reset_n
    |=> ((general_pin_x_oe_n & $past(role_claim)) ==
         (~$past(role_is_out) & $past(role_claim)))
      && ((general_pin_x_out & $past(role_claim)) ==
          ($past(role_level) & $past(role_claim)))
  ) else $error("claimed pin does not follow its serial role");

  chk_general_own: assert property (
    reset_n
    |=> ((general_pin_x_oe_n & ~$past(role_claim)) ==
         (~st_ff.dir & ~$past(role_claim)))
  ) else $error("general pin enable does not follow direction");

  chk_set_bits: assert property (
    (reg_wr && reg_addr == `GPP_OFS_SET)
    |=> (st_ff.lat == ($past(st_ff.lat) | $past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB])))
  ) else $error("set write did not raise exactly the written bits");

  chk_set_pin: assert property (
    (reg_wr && reg_addr == `GPP_OFS_SET && role_claim == '0)
    |=> ((general_pin_x_out & ~general_pin_x_oe_n & $past(reg_wdata[5:0])) ==
         (~general_pin_x_oe_n & $past(reg_wdata[5:0])))
  ) else $error("driven pin not high after set write");

  chk_clr_bits: assert property (
    (reg_wr && reg_addr == `GPP_OFS_CLR)
    |=> (st_ff.lat == ($past(st_ff.lat) & ~$past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB])))
  ) else $error("clear write did not lower exactly the written bits");

  chk_clr_pin: assert property (
    (reg_wr && reg_addr == `GPP_OFS_CLR && role_claim == '0)
    |=> ((general_pin_x_out & $past(reg_wdata[5:0])) == '0)
  ) else $error("pin not low after clear write");

  chk_latch_hold: assert property (
    !(reg_wr && (reg_addr == `GPP_OFS_SET || reg_addr == `GPP_OFS_CLR))
    |=> $stable(st_ff.lat)
  ) else $error("output latch changed without a set or clear write");

  chk_status_read: assert property (
    ($stable(general_pin_x_in) [*3]) ##0 (reg_rd && reg_addr == `GPP_OFS_STS)
    |=> (reg_rdata == {`GPP_RSV_RD, $past(general_pin_x_in)})
  ) else $error("status read does not return the steady pin level");

  chk_status_ro: assert property (
    (reg_wr && reg_addr == `GPP_OFS_STS)
    |=> ($stable(st_ff.dir) && $stable(st_ff.lat))
  ) else $error("write to status changed port state");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == `GPP_DATA_RST)
  ) else $error("read data not zero outside a read answer");

  chk_latch_show: assert property (
    (reg_wr && reg_addr == `GPP_OFS_DIR && role_claim == '0)
    |=> ((general_pin_x_out & st_ff.dir) == (st_ff.lat & st_ff.dir))
  ) else $error("latched value not shown when pin turns to output");

  chk_latch_input: assert property (
    (reg_wr && reg_addr == `GPP_OFS_SET && st_ff.dir == '0)
    ##1 (reg_wr && reg_addr == `GPP_OFS_DIR && role_claim == '0)
    |=> ((general_pin_x_out & $past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB], 2) & st_ff.dir) ==
         ($past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB], 2) & st_ff.dir))
  ) else $error("set written while input was lost");

  chk_clr_input: assert property (
    (reg_wr && reg_addr == `GPP_OFS_CLR && st_ff.dir == '0)
    ##1 (reg_wr && reg_addr == `GPP_OFS_DIR && role_claim == '0)
    |=> ((general_pin_x_out & st_ff.dir &
          $past(reg_wdata[`GPP_PIN_MSB:`GPP_PIN_LSB], 2)) == '0)
  ) else $error("clear written while input was lost");

  chk_set_input: assert property (
    (reg_wr && reg_addr == `GPP_OFS_SET && st_ff.dir == '0 && role_claim == '0)
    |=> (general_pin_x_oe_n == '1)
  ) else $error("set write drove a pin that is an input");

  chk_out_general: assert property (
    reset_n
    |=> ((general_pin_x_out & ~$past(role_claim)) == (st_ff.lat & ~$past(role_claim)))
  ) else $error("general pin output does not show the latch");

  chk_dir_hold: assert property (
    !(reg_wr && reg_addr == `GPP_OFS_DIR)
    |=> $stable(st_ff.dir)
  ) else $error("direction changed without a direction write");

  chk_rsv_zero: assert property (
    reg_rdata[`GPP_DATA_W-1:`GPP_PIN_MSB+1] == `GPP_RSV_RD
  ) else $error("reserved read data bits not zero");

  chk_unmapped_write: assert property (
    (reg_wr && reg_addr > `GPP_OFS_STS)
    |=> ($stable(st_ff.dir) && $stable(st_ff.lat))
  ) else $error("write to an unmapped address changed port state");

  chk_read_no_side: assert property (
    reg_rd
    |=> ($stable(st_ff.dir) && $stable(st_ff.lat))
  ) else $error("register read changed port state");

  chk_set_readback: assert property (
    (reg_rd && reg_addr == `GPP_OFS_SET)
    |=> (reg_rdata == {`GPP_RSV_RD, $past(st_ff.lat)})
  ) else $error("set register readback does not show the latch");

  chk_clr_readback: assert property (
    (reg_rd && reg_addr == `GPP_OFS_CLR)
    |=> (reg_rdata == {`GPP_RSV_RD, $past(st_ff.lat)})
  ) else $error("clear register readback does not show the latch");

  chk_status_source: assert property (
    (reg_rd && reg_addr == `GPP_OFS_STS)
    |=> (reg_rdata == {`GPP_RSV_RD, $past(pin_level)})
  ) else $error("status readback differs from the synchronised level");

  chk_unmapped_read: assert property (
    (reg_rd && reg_addr > `GPP_OFS_STS)
    |=> (reg_rdata == `GPP_DATA_RST)
  ) else $error("read of an unmapped address returned data");

  chk_rdata_once: assert property (
    (reg_rd ##1 !reg_rd)
    |=> (reg_rdata == `GPP_DATA_RST)
  ) else $error("read data stood longer than one cycle");

  chk_sync_first: assert property (
    reset_n
    |=> (st_ff.sync_a == $past(general_pin_x_in))
  ) else $error("first sampling stage missed the pin level");

  chk_level_delay: assert property (
    (reset_n ##1 reset_n)
    |=> (pin_level == $past(general_pin_x_in, 2))
  ) else $error("pin level not two cycles behind the pin");

  chk_role_drive: assert property (
    reset_n
    |=> ((~general_pin_x_oe_n & $past(role_claim)) ==
         ($past(role_is_out) & $past(role_claim)))
  ) else $error("claimed pin drive does not follow its role");

  chk_set_no_clear: assert property (
    (reg_wr && reg_addr == `GPP_OFS_SET)
    |=> ((st_ff.lat & $past(st_ff.lat)) == $past(st_ff.lat))
  ) else $error("set write lowered a latch bit");

  chk_clr_no_set: assert property (
    (reg_wr && reg_addr == `GPP_OFS_CLR)
    |=> ((st_ff.lat & ~$past(st_ff.lat)) == '0)
  ) else $error("clear write raised a latch bit");

endmodule : gpp_general_pin_port

// ==== gpp_general_pin_port_tb.sv ====
`timescale 1ns/1ps

module gpp_general_pin_port_tb;
  import gpp_pkg::*;
  logic ref_clk, reset_n, reg_wr, reg_rd;
  gpp_addr_t reg_addr;
  gpp_data_t reg_wdata, reg_rdata;
  gpp_pins_t role_claim, role_is_out, role_level, ext_level, pin_wire;
  gpp_pins_t pin_out, pin_oe_n, pin_level;
  int failures, samples_checked, dir, lat, drv, lvl, r;
  logic [31:0] seed;

  gpp_general_pin_port uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .role_claim(role_claim), .role_is_out(role_is_out), .role_level(role_level),
    .general_pin_x_in(pin_wire), .general_pin_x_out(pin_out),
    .general_pin_x_oe_n(pin_oe_n), .pin_level(pin_level));
  gpp_ext_pins ext (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
    .pin_wire(pin_wire));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic wr_pair(input logic [7:0] a0, input logic [7:0] d0,
                         input logic [7:0] a1, input logic [7:0] d1);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a0;
    reg_wdata <= d0;
    @(posedge ref_clk);
    reg_addr <= a1;
    reg_wdata <= d1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr_pair

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
    @(posedge ref_clk);
    #1 cmp(reg_rdata, 8'h00);
  endtask : rd

  task automatic check_all();
    repeat (4) @(posedge ref_clk);
    drv = (~role_claim & dir) | (role_claim & role_is_out);
    lvl = ((role_claim & role_level) | (~role_claim & lat)) & drv | ext_level & ~drv;
    #1 cmp(8'(pin_oe_n), 8'(~drv & 6'h3F));
    cmp(8'(pin_out & ~pin_oe_n), 8'(lvl & drv));
    cmp(8'(pin_level), 8'(lvl));
    rd(8'h00, 8'(dir));
    rd(8'h01, 8'(lat));
    rd(8'h02, 8'(lat));
    rd(8'h03, 8'(lvl));
    rd(8'h5A, 8'h00);
  endtask : check_all

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial begin
    #3000000;
    failures++;
    stop_test();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {role_claim, role_is_out, role_level} = '0;
    ext_level = 6'h15;
    seed = 32'h01EE;
    dir = 0;
    lat = 0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 cmp(8'(pin_oe_n), 8'h3F);
    cmp(8'(pin_out), 8'h00);
    cmp(8'(pin_level), 8'h00);
    cmp(reg_rdata, 8'h00);
    check_all();
    $display("test reset done");
    // Latch moves while pins are inputs, then shows once they drive.
    wr(8'h01, 8'h2A);
    lat = 'h2A;
    check_all();
    wr(8'h00, 8'h3F);
    dir = 'h3F;
    check_all();
    wr(8'h03, 8'h3F);
    wr(8'h5A, 8'h3F);
    check_all();
    $display("test latch and refusal done");
    // Reset in mid-run, then back-to-back writes while the pins are inputs.
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    #1 cmp(8'(pin_oe_n), 8'h3F);
    cmp(8'(pin_out), 8'h00);
    cmp(8'(pin_level), 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    dir = 0;
    lat = 0;
    wr_pair(8'h01, 8'h15, 8'h00, 8'h3F);
    lat = 'h15;
    dir = 'h3F;
    check_all();
    wr(8'h00, 8'h00);
    wr_pair(8'h02, 8'h05, 8'h00, 8'h3F);
    lat = 'h10;
    check_all();
    $display("test mid-run reset done");
    for (int i = 0; i < 60; i++) begin
      seed = rnd(seed);
      r = seed % 3;
      wr(8'(r), {2'b00, seed[13:8]});
      if (r == 0) dir = seed[13:8];
      else if (r == 1) lat = lat | seed[13:8];
      else lat = lat & ~seed[13:8];
      if (i % 3 == 0) begin
        @(posedge ref_clk);
        role_claim <= seed[19:14];
        role_is_out <= seed[25:20];
        role_level <= seed[31:26];
        ext_level <= seed[5:0];
      end
      check_all();
    end
    $display("test random traffic done");
    stop_test();
  end
endmodule : gpp_general_pin_port_tb

// ==== gpp_pkg.sv ====
`include "gpp_defs.svh"

package gpp_pkg;

  typedef logic [`GPP_PIN_CNT-1:0] gpp_pins_t;
  typedef logic [`GPP_ADDR_W-1:0]  gpp_addr_t;
  typedef logic [`GPP_DATA_W-1:0]  gpp_data_t;

  // Whole state of the port, registered as one word.
  typedef struct packed {
    gpp_pins_t dir;
    gpp_pins_t lat;
    gpp_pins_t sync_a;
    gpp_pins_t sync_b;
    gpp_pins_t drv_out;
    gpp_pins_t drv_oe_n;
    gpp_data_t rdata;
  } gpp_state_t;

endpackage : gpp_pkg
